// ===== design/uhtl_launch.sv
`timescale 1ns/10ps
module uhtl_launch
(
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // speed configuration from the other control registers
  input  wire logic       low_speed_sel,
  input  wire logic       low_speed_pol,
  // serial engine side
  input  wire logic       sie_busy,
  input  wire logic       sof_sent,
  input  wire logic       xfer_done,
  output logic            launch,
  output logic            launch_set,
  output logic            launch_preamble,
  output logic            launch_iso,
  output logic            launch_dir_out,
  output logic [3:0]      launch_data_pid,
  output logic            xfer_active,
  output logic            done,
  output logic            done_set
);
  import uhtl_pkg::*;

  // ==================================================
  // helpers
  function automatic logic ctrl_go(input logic [7:0] c);
    ctrl_go = c[UHTL_BIT_ENABLE] & c[UHTL_BIT_ARM];
  endfunction

  function automatic logic ctrl_aligned(input logic [7:0] c, input logic ls);
    ctrl_aligned = c[UHTL_BIT_FRAME] & ~ls;
  endfunction

  // ==================================================
  // the two control sets
  uhtl_set_if  set_if [2] ();
  logic [7:0]  ctrl_a [2];
  logic        wr_hit [2];
  logic        clr_hit[2];

  uhtl_set_reg u_set_a
  (
    .clk  (clk),
    .rstn (rstn),
    .sif  (set_if[0])
  );

  uhtl_set_reg u_set_b
  (
    .clk  (clk),
    .rstn (rstn),
    .sif  (set_if[1])
  );

  uhtl_state_t state_q;
  logic        cur_q;
  logic        sof_seen_q;
  logic [7:0]  cur_ctrl;
  logic        go;
  logic        aligned;
  logic        start;
  logic        full_speed;

  always_comb
  begin
    wr_hit[0] = 1'b0;
    wr_hit[1] = 1'b0;
    if (reg_wr && reg_addr == UHTL_OFS_CTRL_A)
    begin
      wr_hit[0] = 1'b1;
    end
    else if (reg_wr && reg_addr == UHTL_OFS_CTRL_B)
    begin
      wr_hit[1] = 1'b1;
    end
  end

  assign clr_hit[0] = (state_q == UHTL_ST_RUN) && xfer_done && (cur_q == 1'b0);
  assign clr_hit[1] = (state_q == UHTL_ST_RUN) && xfer_done && (cur_q == 1'b1);

  assign set_if[0].wr_en   = wr_hit[0];
  assign set_if[0].wdata   = reg_wdata;
  assign set_if[0].clr_arm = clr_hit[0];
  assign set_if[1].wr_en   = wr_hit[1];
  assign set_if[1].wdata   = reg_wdata;
  assign set_if[1].clr_arm = clr_hit[1];
  assign ctrl_a[0]         = set_if[0].ctrl;
  assign ctrl_a[1]         = set_if[1].ctrl;

  // ==================================================
  // launch decision
  // full speed is speed select low; the low-speed polarity input is not used here
  assign full_speed = ~low_speed_sel;
  assign cur_ctrl   = ctrl_a[cur_q];
  assign go         = ctrl_go(cur_ctrl);
  // alignment only honoured at full speed; low speed launches at once
  assign aligned    = ctrl_aligned(cur_ctrl, low_speed_sel);
  assign start      = go && !sie_busy &&
                      ((state_q == UHTL_ST_IDLE && !aligned) ||
                       (state_q == UHTL_ST_SOF && (sof_seen_q || sof_sent)));

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q <= UHTL_ST_IDLE;
    end
    else
    begin
      case (state_q)
        UHTL_ST_IDLE:
        begin
          if (start)
          begin
            state_q <= UHTL_ST_RUN;
          end
          else if (go && aligned)
          begin
            state_q <= UHTL_ST_SOF;
          end
        end
        UHTL_ST_SOF:
        begin
          if (start)
          begin
            state_q <= UHTL_ST_RUN;
          end
          else if (!go)
          begin
            state_q <= UHTL_ST_IDLE;
          end
        end
        UHTL_ST_RUN:
        begin
          if (xfer_done)
          begin
            state_q <= UHTL_ST_IDLE;
          end
        end
        default:
        begin
          state_q <= UHTL_ST_IDLE;
        end
      endcase
    end
  end

  // an sof seen while the engine is busy still counts
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sof_seen_q <= 1'b0;
    end
    else if (state_q != UHTL_ST_SOF || start)
    begin
      sof_seen_q <= 1'b0;
    end
    else if (sof_sent)
    begin
      sof_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cur_q <= UHTL_SET_A;
    end
    else if (state_q == UHTL_ST_RUN && xfer_done)
    begin
      cur_q <= ~cur_q;
    end
  end

  // ==================================================
  // launch descriptor, captured at start
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      launch          <= 1'b0;
      launch_set      <= UHTL_SET_A;
      launch_preamble <= 1'b0;
      launch_iso      <= 1'b0;
      launch_dir_out  <= 1'b0;
      launch_data_pid <= UHTL_PID_DATA0;
    end
    else
    begin
      launch <= start;
      if (start)
      begin
        launch_set      <= cur_q;
        launch_preamble <= cur_ctrl[UHTL_BIT_PREAMBLE] & full_speed;
        launch_iso      <= cur_ctrl[UHTL_BIT_ISO];
        launch_dir_out  <= cur_ctrl[UHTL_BIT_DIR];
        launch_data_pid <= (cur_ctrl[UHTL_BIT_DIR] && cur_ctrl[UHTL_BIT_TOGGLE]) ?
                           UHTL_PID_DATA1 : UHTL_PID_DATA0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      done     <= 1'b0;
      done_set <= UHTL_SET_A;
    end
    else
    begin
      done <= (state_q == UHTL_ST_RUN) && xfer_done;
      if ((state_q == UHTL_ST_RUN) && xfer_done)
      begin
        done_set <= cur_q;
      end
    end
  end

  assign xfer_active = (state_q == UHTL_ST_RUN);

  // ==================================================
  // register readback, one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= UHTL_RDATA_NONE;
    end
    else if (reg_rd)
    begin
      if (reg_addr == UHTL_OFS_CTRL_A)
      begin
        reg_rdata <= ctrl_a[0];
      end
      else if (reg_addr == UHTL_OFS_CTRL_B)
      begin
        reg_rdata <= ctrl_a[1];
      end
      else
      begin
        reg_rdata <= UHTL_RDATA_NONE;
      end
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_launch_needs_go: assert property (launch |-> $past(go))
    else $error("launch without enable and arm");
  a_preamble_speed: assert property (
    launch |-> launch_preamble ==
      ($past(cur_ctrl[UHTL_BIT_PREAMBLE]) && !$past(low_speed_sel)))
    else $error("preamble not following field and speed");
  a_preamble_ls_off: assert property (
    launch && $past(low_speed_sel) && $past(low_speed_pol) |-> !launch_preamble)
    else $error("preamble sent in direct low speed");
  a_toggle_out_only: assert property (
    launch |-> launch_data_pid == (($past(cur_ctrl[UHTL_BIT_DIR]) &&
      $past(cur_ctrl[UHTL_BIT_TOGGLE])) ? UHTL_PID_DATA1 : UHTL_PID_DATA0))
    else $error("data pid mismatch");
  a_sof_hold: assert property (
    state_q == UHTL_ST_SOF && !sof_seen_q && !sof_sent |=> !launch)
    else $error("aligned packet sent before sof");
  a_immediate_go: assert property (
    state_q == UHTL_ST_IDLE && go && !aligned && !sie_busy |=> launch)
    else $error("free engine did not launch");
  a_busy_blocks: assert property (sie_busy |=> !launch)
    else $error("launch while engine busy");
  a_iso_dir_copy: assert property (
    launch |-> launch_iso == $past(cur_ctrl[UHTL_BIT_ISO]) &&
      launch_dir_out == $past(cur_ctrl[UHTL_BIT_DIR]))
    else $error("iso or direction not carried");
  a_reserved_zero: assert property (
    reg_rd |=> !reg_rdata[UHTL_BIT_RSVD])
    else $error("reserved bit read nonzero");
  a_done_clears_arm: assert property (
    done && !$past(wr_hit[0]) && !$past(wr_hit[1]) |->
      !ctrl_a[done_set][UHTL_BIT_ARM])
    else $error("arm still set after done");
  a_set_alternate: assert property (done |-> cur_q != done_set)
    else $error("set did not alternate");
  a_arm_while_run: assert property (
    state_q == UHTL_ST_RUN && !$past(wr_hit[cur_q]) |-> ctrl_a[cur_q][UHTL_BIT_ARM])
    else $error("arm low during transfer");

  c_launch_a: cover property (launch && launch_set == 1'b0);
  c_launch_b: cover property (launch && launch_set == 1'b1);
  c_sof_launch: cover property (state_q == UHTL_ST_SOF ##[1:80] launch);
  c_done: cover property (done ##[1:20] launch);
endmodule

// ===== design/uhtl_pkg.sv
// ==================================================
// host transfer launch constants
package uhtl_pkg;

  // ==================================================
  // register map, byte offsets on the register port
  localparam logic [7:0] UHTL_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] UHTL_OFS_CTRL_B = 8'h08;

  // ==================================================
  // host_transfer_control field positions
  localparam int UHTL_BIT_PREAMBLE = 7;
  localparam int UHTL_BIT_TOGGLE   = 6;
  localparam int UHTL_BIT_FRAME    = 5;
  localparam int UHTL_BIT_ISO      = 4;
  localparam int UHTL_BIT_RSVD     = 3;
  localparam int UHTL_BIT_DIR      = 2;
  localparam int UHTL_BIT_ENABLE   = 1;
  localparam int UHTL_BIT_ARM      = 0;

  // ==================================================
  // reset values and bus answers
  localparam logic       UHTL_ARM_RESET  = 1'b0;
  localparam logic [7:0] UHTL_RDATA_NONE = 8'h00;
  localparam logic       UHTL_SET_A      = 1'b0;

  // ==================================================
  // data pid codes handed to the serial engine
  localparam logic [3:0] UHTL_PID_DATA0 = 4'h3;
  localparam logic [3:0] UHTL_PID_DATA1 = 4'hB;

  // ==================================================
  // launch sequencer states
  typedef enum logic [2:0]
  {
    UHTL_ST_IDLE = 3'b001,
    UHTL_ST_SOF  = 3'b010,
    UHTL_ST_RUN  = 3'b100
  } uhtl_state_t;

endpackage

// ===== design/uhtl_set_if.sv
`timescale 1ns/10ps
// ==================================================
// one host control set: write port, arm clear, readback
interface uhtl_set_if;
  logic       wr_en;
  logic [7:0] wdata;
  logic       clr_arm;
  logic [7:0] ctrl;

  modport ctl
  (
    output wr_en,
    output wdata,
    output clr_arm,
    input  ctrl
  );

  modport store
  (
    input  wr_en,
    input  wdata,
    input  clr_arm,
    output ctrl
  );
endinterface

// ===== design/uhtl_set_reg.sv
`timescale 1ns/10ps
module uhtl_set_reg
(
  input  wire logic clk,
  input  wire logic rstn,
  uhtl_set_if.store sif
);
  import uhtl_pkg::*;

  logic [7:1] fields_q;
  logic       arm_q;

  // ==================================================
  // fields other than arm carry no reset on purpose
  always_ff @(posedge clk)
  begin
    if (sif.wr_en)
    begin
      fields_q <= sif.wdata[7:1];
    end
  end

  // ==================================================
  // a software write in the clear cycle wins so a re-arm is kept
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      arm_q <= UHTL_ARM_RESET;
    end
    else if (sif.wr_en)
    begin
      arm_q <= sif.wdata[UHTL_BIT_ARM];
    end
    else if (sif.clr_arm)
    begin
      arm_q <= 1'b0;
    end
  end

  // reserved bit always reads zero
  assign sif.ctrl = {fields_q[7:4], 1'b0, fields_q[2:1], arm_q};

  a_arm_reset_zero: assert property (@(posedge clk) !rstn |=> !arm_q)
    else $error("arm not cleared by reset");
  a_arm_hw_clear: assert property (@(posedge clk) disable iff (!rstn)
    sif.clr_arm && !sif.wr_en |=> !arm_q)
    else $error("arm survived completion");
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
  import uhtl_pkg::*;
  // ========
  // signals
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        lss = 1'b0;
  logic [4:0]  dly = 5'h08;
  logic [7:0]  reg_rdata;
  logic        sie_busy;
  logic        sof_sent;
  logic        xfer_done;
  logic        launch;
  logic        l_set;
  logic        l_pre;
  logic        l_iso;
  logic        l_dir;
  logic [3:0]  l_pid;
  logic        active;
  logic        done;
  logic        d_set;
  logic [7:0]  cb [2];
  logic [7:0]  rv;
  logic [31:0] r;
  logic        pb = 1'b0;
  logic        sof_f = 1'b0;
  logic        c_sof = 1'b0;
  integer      seed = 92943;
  int          n_errors = 0;
  int          checked = 0;
  int          n_launch = 0;
  int          n_done = 0;
  int          nl = 0;
  int          nd = 0;

  always #4 clk = ~clk;

  uhtl_launch i_dut
  (
    .clk             (clk),
    .rstn            (rstn),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .low_speed_sel   (lss),
    .low_speed_pol   (lss),
    .sie_busy        (sie_busy),
    .sof_sent        (sof_sent),
    .xfer_done       (xfer_done),
    .launch          (launch),
    .launch_set      (l_set),
    .launch_preamble (l_pre),
    .launch_iso      (l_iso),
    .launch_dir_out  (l_dir),
    .launch_data_pid (l_pid),
    .xfer_active     (active),
    .done            (done),
    .done_set        (d_set)
  );

  uhtl_sie_model i_sie
  (
    .clk       (clk),
    .rstn      (rstn),
    .launch    (launch),
    .dly       (dly),
    .sie_busy  (sie_busy),
    .sof_sent  (sof_sent),
    .xfer_done (xfer_done)
  );

  // ========
  // tasks
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(negedge clk)
  begin
    if (launch === 1'b1)
    begin
      chk(pb === 1'b0, "launch while busy");
      c_sof = sof_f;
      sof_f = 1'b0;
      n_launch++;
    end
    // an sof that coincides with done falls in the idle cycle and must not count
    if (sof_sent === 1'b1)
      sof_f = 1'b1;
    if (done === 1'b1)
    begin
      sof_f = 1'b0;
      n_done++;
    end
    pb = sie_busy;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // an sof before the arming write cannot release an aligned wait
    sof_f = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask

  task automatic wt(input int t, input logic on_d);
    for (int i = 0; i < 400; i++)
    begin
      if ((on_d ? n_done : n_launch) >= t)
        return;
      @(negedge clk);
    end
    chk(1'b0, "timeout");
    results();
  endtask

  // frame bit kept clear at low speed
  function automatic logic [7:0] mk(input logic [31:0] x, input logic ls);
    // preamble bit picks a hub-side low-speed target or a full-speed one
    mk = {x[7:6], x[5] & ~ls, x[4:2], 2'b11};
  endfunction

  function automatic logic [7:0] rb(input logic [7:0] c, input logic arm);
    rb = {c[7:4], 1'b0, c[2:1], arm};
  endfunction

  task automatic serve(input logic s);
    nl++;
    wt(nl, 1'b0);
    chk(l_set === s, "set order");
    chk(l_pre === (cb[s][7] & ~lss), "preamble");
    chk(l_pid === ((cb[s][2] & cb[s][6]) ? UHTL_PID_DATA1 : UHTL_PID_DATA0), "pid");
    chk(l_iso === cb[s][4], "iso");
    chk(l_dir === cb[s][2], "direction");
    chk(~cb[s][5] | lss | c_sof, "frame align");
    rd(s ? UHTL_OFS_CTRL_B : UHTL_OFS_CTRL_A);
    chk(rv === rb(cb[s], 1'b1) && active === 1'b1, "arm busy");
    nd++;
    wt(nd, 1'b1);
    chk(d_set === s && active === 1'b0, "done set");
    rd(s ? UHTL_OFS_CTRL_B : UHTL_OFS_CTRL_A);
    chk(rv === rb(cb[s], 1'b0), "arm clear");
  endtask

  // ========
  // stimulus
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    rd(UHTL_OFS_CTRL_A);
    chk(rv[0] === UHTL_ARM_RESET, "arm reset a");
    rd(UHTL_OFS_CTRL_B);
    chk(rv[0] === UHTL_ARM_RESET, "arm reset b");
    wr(8'h05, 8'hff);
    rd(8'h05);
    chk(rv === UHTL_RDATA_NONE, "unmapped");
    // set a armed but not enabled blocks an enabled set b
    cb[1] = mk($random(seed), lss);
    wr(UHTL_OFS_CTRL_A, 8'h01);
    wr(UHTL_OFS_CTRL_B, cb[1]);
    repeat (40) @(negedge clk);
    chk(n_launch == 0, "start without enable");
    for (int i = 0; i < 24; i++)
    begin
      cb[0] = mk($random(seed), lss);
      wr(UHTL_OFS_CTRL_A, cb[0]);
      serve(1'b0);
      serve(1'b1);
      r = $random(seed);
      lss = r[8];
      dly = {1'b0, r[3:0]} + 5'h04;
      cb[1] = mk($random(seed), lss);
      wr(UHTL_OFS_CTRL_B, cb[1]);
    end
    results();
  end
endmodule

// ===== test/uhtl_sie_model.sv
`timescale 1ns/10ps
// ========
// engine stand-in: busy from launch to done, then a short tail
module uhtl_sie_model
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       launch,
  input  wire logic [4:0] dly,
  output logic            sie_busy,
  output logic            sof_sent,
  output logic            xfer_done
);
  logic [5:0] sof_q;
  logic [4:0] cnt_q;
  logic       run_q;
  logic [1:0] tail_q;

  assign sie_busy = run_q | (tail_q != 2'h0);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      sof_q <= 6'h00;
    else
      sof_q <= sof_q + 6'h01;
  end

  always_ff @(posedge clk)
  begin
    sof_sent <= rstn && (sof_q == 6'h3f);
  end

  // tail keeps the engine busy so the other set must hold off
  always_ff @(posedge clk)
  begin
    xfer_done <= 1'b0;
    if (!rstn)
    begin
      run_q  <= 1'b0;
      cnt_q  <= 5'h00;
      tail_q <= 2'h0;
    end
    else if (launch)
    begin
      run_q <= 1'b1;
      cnt_q <= dly;
    end
    else if (run_q && cnt_q == 5'h00)
    begin
      run_q     <= 1'b0;
      xfer_done <= 1'b1;
      tail_q    <= 2'h3;
    end
    else if (run_q)
      cnt_q <= cnt_q - 5'h01;
    else if (tail_q != 2'h0)
      tail_q <= tail_q - 2'h1;
  end
endmodule
